// ==== design/wdw_top.sv ====
// Windowed down-count watchdog: 7-bit free-running counter, prescaler,
// activation latch, reset pulse generator and timeout-limit reporter.
// Assumes MCLK is the oscillator clock and all inputs except the asynchronous reset RST_N are synchronous.
module wdw_top (
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  input  wire logic        CTRL_WR,
  input  wire logic [7:0]  CTRL_WDATA,
  output logic      [7:0]  CTRL_RDATA,
  input  wire logic [1:0]  TIMEBASE_SELECT,
  input  wire logic        HW_WATCHDOG_OPT,
  input  wire logic        HALT_RESET_OPT,
  input  wire logic        HALT_EXEC,
  output logic             HALT_ENTER,
  output logic             WDG_ACTIVE,
  output logic             RESET_PIN_O,
  output logic             RESET_PIN_OE,
  output logic      [23:0] TIMEOUT_MIN,
  output logic      [23:0] TIMEOUT_MAX
);

  // ----------------------------------------------------------------
  // Timebase constants
  // ----------------------------------------------------------------
  function automatic int unsigned tb_msb(input logic [1:0] tb);
    int unsigned r;
    r = wdw_pkg::MSB_2MS;
    unique case (tb)
      wdw_pkg::TB_2MS:  r = wdw_pkg::MSB_2MS;
      wdw_pkg::TB_4MS:  r = wdw_pkg::MSB_4MS;
      wdw_pkg::TB_10MS: r = wdw_pkg::MSB_10MS;
      wdw_pkg::TB_25MS: r = wdw_pkg::MSB_25MS;
    endcase
    return r;
  endfunction

  function automatic int unsigned tb_lsb(input logic [1:0] tb);
    int unsigned r;
    r = wdw_pkg::LSB_2MS;
    unique case (tb)
      wdw_pkg::TB_2MS:  r = wdw_pkg::LSB_2MS;
      wdw_pkg::TB_4MS:  r = wdw_pkg::LSB_4MS;
      wdw_pkg::TB_10MS: r = wdw_pkg::LSB_10MS;
      wdw_pkg::TB_25MS: r = wdw_pkg::LSB_25MS;
    endcase
    return r;
  endfunction

  // Timeout limit in oscillator periods; upper selects the maximum
  function automatic logic [23:0] timeout(input logic [5:0] cnt_in,
                                          input logic [1:0] tb,
                                          input logic       upper);
    int unsigned msb;
    int unsigned lsb;
    int unsigned cnt;
    int unsigned q;
    int unsigned base;
    logic        linear;
    int unsigned r;
    msb  = tb_msb(tb);
    lsb  = tb_lsb(tb);
    cnt  = int'(cnt_in);
    q    = (wdw_pkg::QUARTER * cnt) / msb;
    base = upper ? wdw_pkg::PRESC_DIV
                 : (lsb + wdw_pkg::MIN_OFS) * wdw_pkg::STEP_MUL;
    linear = upper ? (cnt <= msb / wdw_pkg::QUARTER)
                   : (cnt < msb / wdw_pkg::QUARTER);
    if (linear) begin
      r = base + wdw_pkg::PRESC_DIV * cnt;
    end else begin
      r = base + wdw_pkg::PRESC_DIV * (cnt - q)
          + (wdw_pkg::STEP_OFS + lsb) * wdw_pkg::STEP_MUL * q;
    end
    return r[23:0];
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  wdw_pkg::wdw_regs_t r_q;
  wdw_pkg::wdw_regs_t r_d;

  logic       active;
  logic       tick;
  logic       act_after_wr;
  logic       wr_trip;
  logic       cnt_trip;
  logic       halt_trip;
  logic [6:0] cnt_dec;

  always_comb begin
    active       = r_q.act | HW_WATCHDOG_OPT;
    tick         = (r_q.presc == wdw_pkg::PRESC_LAST);
    cnt_dec      = r_q.cnt - wdw_pkg::CNT_ONE;
    act_after_wr = active | CTRL_WDATA[wdw_pkg::ACT_BIT];
    wr_trip      = CTRL_WR & act_after_wr & ~CTRL_WDATA[wdw_pkg::TOP_BIT];
    // Inactive underflow produces nothing
    cnt_trip     = ~CTRL_WR & tick & active & (r_q.cnt == wdw_pkg::CNT_EXPIRE);
    halt_trip    = HALT_EXEC & active & HALT_RESET_OPT;

    r_d            = r_q;
    r_d.halt_enter = 1'b0;
    // Prescaler free-runs; never cleared by writes
    r_d.presc      = r_q.presc + wdw_pkg::PRESC_ONE;

    unique case (r_q.state)
      wdw_pkg::ST_RUN: begin
        if (CTRL_WR) begin
          r_d.cnt = CTRL_WDATA[wdw_pkg::CNT_W-1:0];
          r_d.act = r_q.act | CTRL_WDATA[wdw_pkg::ACT_BIT];
        end else if (tick) begin
          r_d.cnt = cnt_dec;
        end
        if (HALT_EXEC & ~halt_trip) begin
          r_d.halt_enter = 1'b1;
        end
        if (wr_trip | cnt_trip | halt_trip) begin
          r_d.state     = wdw_pkg::ST_PULSE;
          r_d.pulse     = wdw_pkg::RST_PULSE_CYC;
          r_d.rst_drive = 1'b1;
          r_d.halt_enter = 1'b0;
        end
      end
      wdw_pkg::ST_PULSE: begin
        if (tick) begin
          r_d.cnt = cnt_dec;
        end
        if (r_q.pulse == wdw_pkg::PULSE_ONE) begin
          // Pulse done: state, activation and counter return to their reset values; prescaler keeps counting
          r_d.state     = wdw_pkg::ST_RUN;
          r_d.rst_drive = 1'b0;
          r_d.act       = 1'b0;
          r_d.cnt       = wdw_pkg::CTRL_RESET[wdw_pkg::CNT_W-1:0];
        end else begin
          r_d.pulse = r_q.pulse - wdw_pkg::PULSE_ONE;
        end
      end
    endcase

    r_d.tmin = timeout(r_d.cnt[wdw_pkg::LOADED_W-1:0], TIMEBASE_SELECT, 1'b0);
    r_d.tmax = timeout(r_d.cnt[wdw_pkg::LOADED_W-1:0], TIMEBASE_SELECT, 1'b1);
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      r_q.state      <= wdw_pkg::ST_RUN;
      r_q.act        <= wdw_pkg::CTRL_RESET[wdw_pkg::ACT_BIT];
      r_q.cnt        <= wdw_pkg::CTRL_RESET[wdw_pkg::CNT_W-1:0];
      r_q.presc      <= '0;
      r_q.pulse      <= '0;
      r_q.rst_drive  <= 1'b0;
      r_q.halt_enter <= 1'b0;
      r_q.tmin       <= '0;
      r_q.tmax       <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    CTRL_RDATA   = {r_q.act, r_q.cnt};
    WDG_ACTIVE   = r_q.act | HW_WATCHDOG_OPT;
    HALT_ENTER   = r_q.halt_enter;
    // Open-drain reset pin: drives low only
    RESET_PIN_O  = 1'b0;
    RESET_PIN_OE = r_q.rst_drive;
    TIMEOUT_MIN  = r_q.tmin;
    TIMEOUT_MAX  = r_q.tmax;
  end

endmodule

// ==== common/wdw_pkg.sv ====
// Constants and types of the windowed down-count watchdog.
// Assumes MCLK is the internal oscillator clock that feeds the prescaler.
package wdw_pkg;

  // ----------------------------------------------------------------
  // Control register layout
  // ----------------------------------------------------------------
  localparam int unsigned       CTRL_W       = 8;
  localparam int unsigned       CNT_W        = 7;
  localparam int unsigned       LOADED_W     = 6;
  localparam int unsigned       ACT_BIT      = 7;
  localparam int unsigned       TOP_BIT      = 6;
  localparam logic [7:0]        CTRL_RESET   = 8'h7F;
  localparam logic [6:0]        CNT_EXPIRE   = 7'h40;
  localparam logic [6:0]        CNT_ONE      = 7'h01;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned       PRESC_W      = 14;
  localparam int unsigned       PRESC_DIV    = 16384;
  localparam logic [13:0]       PRESC_LAST   = 14'(PRESC_DIV - 1);
  localparam logic [13:0]       PRESC_ONE    = 14'h0001;
  localparam int unsigned       CLK_PERIOD_PS = 5000;
  localparam int unsigned       RST_PULSE_NS = 500;
  localparam int unsigned       RST_PULSE_CYC_I =
    ((RST_PULSE_NS * 1000) / CLK_PERIOD_PS < 1) ? 1 : (RST_PULSE_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned       PULSE_W      = 8;
  localparam logic [7:0]        RST_PULSE_CYC = 8'(RST_PULSE_CYC_I);
  localparam logic [7:0]        PULSE_ONE    = 8'h01;

  // ----------------------------------------------------------------
  // Timeout limit arithmetic
  // ----------------------------------------------------------------
  localparam int unsigned       TOUT_W       = 24;
  localparam int unsigned       MIN_OFS      = 128;
  localparam int unsigned       STEP_OFS     = 192;
  localparam int unsigned       STEP_MUL     = 64;
  localparam int unsigned       QUARTER      = 4;

  // Timebase codes: 2 ms, 4 ms, 10 ms, 25 ms
  localparam logic [1:0]        TB_2MS       = 2'h0;
  localparam logic [1:0]        TB_4MS       = 2'h1;
  localparam logic [1:0]        TB_10MS      = 2'h2;
  localparam logic [1:0]        TB_25MS      = 2'h3;
  localparam int unsigned       MSB_2MS      = 4;
  localparam int unsigned       MSB_4MS      = 8;
  localparam int unsigned       MSB_10MS     = 20;
  localparam int unsigned       MSB_25MS     = 49;
  localparam int unsigned       LSB_2MS      = 59;
  localparam int unsigned       LSB_4MS      = 53;
  localparam int unsigned       LSB_10MS     = 35;
  localparam int unsigned       LSB_25MS     = 54;

  typedef enum logic [0:0] {
    ST_RUN,
    ST_PULSE
  } wdw_state_t;

  typedef struct packed {
    wdw_state_t     state;
    logic           act;
    logic [6:0]     cnt;
    logic [13:0]    presc;
    logic [7:0]     pulse;
    logic           rst_drive;
    logic           halt_enter;
    logic [23:0]    tmin;
    logic [23:0]    tmax;
  } wdw_regs_t;

endpackage

// ==== bench/wdw_sva.sv ====
// Port assertions for the watchdog top.
// Bound into wdw_top; sees only its ports, one clock domain.
module wdw_sva (
  input wire logic       MCLK,
  input wire logic       RST_N,
  input wire logic       CTRL_WR,
  input wire logic [7:0] CTRL_WDATA,
  input wire logic [7:0] CTRL_RDATA,
  input wire logic       WDG_ACTIVE,
  input wire logic       HALT_EXEC,
  input wire logic       HALT_RESET_OPT,
  input wire logic       HALT_ENTER,
  input wire logic       RESET_PIN_O,
  input wire logic       RESET_PIN_OE
);
  // ------------------------------------------------------------
  // Pulse width counter
  // ------------------------------------------------------------
  logic [7:0] hi_q;
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) hi_q <= 8'h00;
    else hi_q <= RESET_PIN_OE ? hi_q + 8'h01 : 8'h00;
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  AST_PIN_LOW: assert property (RESET_PIN_O == 1'b0)
    else $error("reset pin data not low");
  AST_PULSE_LEN: assert property (!RESET_PIN_OE && $past(RESET_PIN_OE) |-> hi_q == 8'h64)
    else $error("reset pulse width wrong");
  AST_SW_RST: assert property (CTRL_WR && CTRL_WDATA[7:6] == 2'h2 && !RESET_PIN_OE |=> RESET_PIN_OE)
    else $error("software reset missing");
  AST_HALT_RST: assert property (HALT_EXEC && WDG_ACTIVE && HALT_RESET_OPT && !RESET_PIN_OE
    |=> RESET_PIN_OE)
    else $error("halt reset missing");
  AST_HALT_IN: assert property (HALT_EXEC && !(WDG_ACTIVE && HALT_RESET_OPT) && !CTRL_WR
    && CTRL_RDATA[6:0] != 7'h40 && !RESET_PIN_OE |=> HALT_ENTER)
    else $error("halt entry missing");
  AST_LOAD: assert property (CTRL_WR && CTRL_WDATA[6] && !RESET_PIN_OE
    |=> CTRL_RDATA[6:0] == $past(CTRL_WDATA[6:0]))
    else $error("write did not load counter");
  AST_ACT_STICKY: assert property (CTRL_RDATA[7] && !RESET_PIN_OE
    |=> CTRL_RDATA[7] || RESET_PIN_OE)
    else $error("activation cleared");
  AST_EXPIRE: assert property (WDG_ACTIVE && !CTRL_WR && !RESET_PIN_OE && CTRL_RDATA[6:0] == 7'h40
    ##1 CTRL_RDATA[6:0] == 7'h3F |-> RESET_PIN_OE)
    else $error("expiry without reset");
  AST_QUIET: assert property (!WDG_ACTIVE && !CTRL_WR && !HALT_EXEC && !RESET_PIN_OE
    |=> !RESET_PIN_OE)
    else $error("reset while inactive");
  COV_PULSE: cover property ($rose(RESET_PIN_OE));
  COV_HALT: cover property (HALT_ENTER);
  COV_EXP: cover property (WDG_ACTIVE && CTRL_RDATA[6:0] == 7'h40 ##1 RESET_PIN_OE);
endmodule
bind wdw_top wdw_sva wdw_sva_i (.MCLK, .RST_N, .CTRL_WR, .CTRL_WDATA, .CTRL_RDATA,
  .WDG_ACTIVE, .HALT_EXEC, .HALT_RESET_OPT, .HALT_ENTER, .RESET_PIN_O, .RESET_PIN_OE);

// ==== bench/wdw_tb_top.sv ====
// Self-checking bench for the watchdog top.
// Drives all inputs at the falling edge of a 200 MHz MCLK.
module wdw_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        MCLK, RST_N, CTRL_WR, HW_WATCHDOG_OPT, HALT_RESET_OPT, HALT_EXEC;
  logic        HALT_ENTER, WDG_ACTIVE, RESET_PIN_O, RESET_PIN_OE;
  logic [1:0]  TIMEBASE_SELECT;
  logic [7:0]  CTRL_WDATA, CTRL_RDATA;
  logic [23:0] TIMEOUT_MIN, TIMEOUT_MAX;
  int          n_fail = 0;
  int          num_checks = 0;
  wdw_top wdw_top_i (.MCLK, .RST_N, .CTRL_WR, .CTRL_WDATA, .CTRL_RDATA, .TIMEBASE_SELECT,
    .HW_WATCHDOG_OPT, .HALT_RESET_OPT, .HALT_EXEC, .HALT_ENTER, .WDG_ACTIVE, .RESET_PIN_O,
    .RESET_PIN_OE, .TIMEOUT_MIN, .TIMEOUT_MAX);
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] d);
    @(negedge MCLK);
    CTRL_WR = 1'b1;
    CTRL_WDATA = d;
    @(negedge MCLK);
    CTRL_WR = 1'b0;
  endtask
  // Waits for the pulse within lim cycles, then measures it
  task automatic pulse(input int lim);
    int i = 0;
    int w = 0;
    while (RESET_PIN_OE !== 1'b1 && i < lim) begin
      @(negedge MCLK);
      i++;
    end
    if (i >= lim) begin
      n_fail++;
      results();
    end
    while (RESET_PIN_OE === 1'b1 && w < 200) begin
      @(negedge MCLK);
      w++;
    end
    chk(24'(w), 24'h64);
    chk(CTRL_RDATA, 8'h7F);
  endtask
  // Counts cycles until the counter moves
  task automatic tick(output int i);
    logic [7:0] old = CTRL_RDATA;
    i = 0;
    while (CTRL_RDATA === old && i < 16400) begin
      @(negedge MCLK);
      i++;
    end
    if (i >= 16400) begin
      n_fail++;
      results();
    end
  endtask
  task automatic halt(input logic opt);
    HALT_RESET_OPT = opt;
    @(negedge MCLK);
    HALT_EXEC = 1'b1;
    @(negedge MCLK);
    HALT_EXEC = 1'b0;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_tout();
    int lsb[4] = '{59, 53, 35, 54};
    chk(CTRL_RDATA, 8'h7F);
    chk(WDG_ACTIVE, 1'b0);
    for (int t = 0; t < 4; t++) begin
      TIMEBASE_SELECT = 2'(t);
      wr(8'h40);
      repeat (2) @(negedge MCLK);
      chk(TIMEOUT_MIN, 24'((lsb[t] + 128) * 64));
      chk(TIMEOUT_MAX, 24'h4000);
    end
    TIMEBASE_SELECT = 2'h0;
    wr(8'h41);
    repeat (2) @(negedge MCLK);
    chk(TIMEOUT_MIN, 24'h6D80);
    chk(TIMEOUT_MAX, 24'h8000);
    wr(8'h7F);
    repeat (2) @(negedge MCLK);
    chk(TIMEOUT_MIN, 24'h0F_A000);
    chk(TIMEOUT_MAX, 24'h0F_B140);
    $display("timeout limits done");
  endtask
  task automatic t_free();
    int i;
    wr(8'h45);
    tick(i);
    chk(CTRL_RDATA, 8'h44);
    wr(8'h50);
    tick(i);
    chk(24'(i), 24'h3FFE);
    chk(CTRL_RDATA, 8'h4F);
    $display("free run done");
  endtask
  task automatic t_expire();
    wr(8'hFF);
    wr(8'h70);
    chk(CTRL_RDATA, 8'hF0);
    wr(8'hC0);
    pulse(16400);
    wr(8'h80);
    pulse(1);
    $display("expiry done");
  endtask
  task automatic t_halt();
    halt(1'b1);
    chk(HALT_ENTER, 1'b1);
    wr(8'hFF);
    halt(1'b0);
    chk(HALT_ENTER, 1'b1);
    halt(1'b1);
    pulse(1);
    HW_WATCHDOG_OPT = 1'b1;
    @(negedge MCLK);
    chk(WDG_ACTIVE, 1'b1);
    $display("halt done");
  endtask
  // ------------------------------------------------------------
  // Clock and main sequence
  // ------------------------------------------------------------
  initial begin
    MCLK = 1'b0;
    forever #2.5 MCLK = ~MCLK;
  end
  initial begin
    {RST_N, CTRL_WR, CTRL_WDATA, TIMEBASE_SELECT} = '0;
    {HW_WATCHDOG_OPT, HALT_RESET_OPT, HALT_EXEC} = '0;
    repeat (3) @(negedge MCLK);
    RST_N = 1'b1;
    t_tout();
    t_free();
    t_expire();
    t_halt();
    results();
  end
endmodule
